/* mmf_pkg.sv */
// Constants of the memory model feature identification bank.
// Assumes one core clock; every value here is fixed at build time.
package mmf_pkg;

  // Coprocessor read fields that select this bank
  localparam logic [2:0] OPC1_ID  = 3'h0;
  localparam logic [3:0] CRN_ID   = 4'h0;
  localparam logic [3:0] CRM_FEAT = 4'h1;
  localparam logic [2:0] OPC2_AUX = 3'h3;
  localparam logic [2:0] OPC2_MM0 = 3'h4;
  localparam logic [2:0] OPC2_MM1 = 3'h5;

  // Low bit of each 4-bit field, from the top nibble down
  localparam logic [4:0] NIB7_LSB = 5'h1c;
  localparam logic [4:0] NIB6_LSB = 5'h18;
  localparam logic [4:0] NIB5_LSB = 5'h14;
  localparam logic [4:0] NIB4_LSB = 5'h10;
  localparam logic [4:0] NIB3_LSB = 5'h0c;
  localparam logic [4:0] NIB2_LSB = 5'h08;
  localparam logic [4:0] NIB1_LSB = 5'h04;
  localparam logic [4:0] NIB0_LSB = 5'h00;

  // First memory model word fields
  localparam logic [3:0] MM0_RSVD   = 4'h0;
  localparam logic [3:0] MM0_CTX    = 4'h1;
  localparam logic [3:0] MM0_AUXCTL = 4'h1;
  localparam logic [3:0] MM0_COUPLED = 4'h0;
  localparam logic [3:0] MM0_OSH    = 4'h0;
  localparam logic [3:0] MM0_COH    = 4'h0;
  localparam logic [3:0] MM0_PHYS   = 4'h0;
  localparam logic [3:0] MM0_VIRT   = 4'h3;

  // Second memory model word fields
  localparam logic [3:0] MM1_BRANCH = 4'h2;
  localparam logic [3:0] MM1_TSTCLN = 4'h0;
  localparam logic [3:0] MM1_UNIALL = 4'h0;
  localparam logic [3:0] MM1_SPLALL = 4'h0;
  localparam logic [3:0] MM1_UNISW  = 4'h0;
  localparam logic [3:0] MM1_SPLSW  = 4'h0;
  localparam logic [3:0] MM1_UNIVA  = 4'h0;
  localparam logic [3:0] MM1_SPLVA  = 4'h0;

  // Whole words
  localparam logic [31:0] AUX_WORD = 32'h0000_0000;
  localparam logic [31:0] MM0_WORD = {MM0_RSVD, MM0_CTX,
    MM0_AUXCTL, MM0_COUPLED, MM0_OSH, MM0_COH, MM0_PHYS, MM0_VIRT};
  localparam logic [31:0] MM1_WORD = {MM1_BRANCH, MM1_TSTCLN,
    MM1_UNIALL, MM1_SPLALL, MM1_UNISW, MM1_SPLSW, MM1_UNIVA,
    MM1_SPLVA};

  // Values after reset
  localparam logic [31:0] RESP_DATA_RST = 32'h0000_0000;
  localparam logic [3:0]  RESP_RD_RST   = 4'h0;

endpackage

/* mmf_cp_decode.sv */
// Decoder of coprocessor register fields for the feature bank.
// Assumes its inputs are stable in the cycle of a request.
`timescale 1ns/1ps
`default_nettype none

module mmf_cp_decode (
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] opc2,
  output logic            selAux,
  output logic            selMm0,
  output logic            selMm1,
  output logic            bankHit
);

  logic grpHit;

  // Primary, secondary register and first opcode name the group
  assign grpHit = (opc1 == mmf_pkg::OPC1_ID) &&
                  (crn == mmf_pkg::CRN_ID) &&
                  (crm == mmf_pkg::CRM_FEAT);

  // Second opcode picks one word inside the group
  always_comb begin
    selAux = 1'b0;
    selMm0 = 1'b0;
    selMm1 = 1'b0;
    if (!grpHit) begin
      selAux = 1'b0;
    end else if (opc2 == mmf_pkg::OPC2_AUX) begin
      selAux = 1'b1;
    end else if (opc2 == mmf_pkg::OPC2_MM0) begin
      selMm0 = 1'b1;
    end else if (opc2 == mmf_pkg::OPC2_MM1) begin
      selMm1 = 1'b1;
    end
  end

  // Any other second opcode belongs to a neighbouring block
  assign bankHit = selAux | selMm0 | selMm1;

endmodule

`default_nettype wire

/* mmf_feature_regs.sv */
// Feature identification bank answering coprocessor reads.
// Assumes request fields come from core logic on clk, no sync.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Auxiliary feature word always reads zero
// - One copy, same value in both states
// - Only privileged reads return data
// - Writes and user accesses give undefined
// - Second opcode 3 selects auxiliary word
// - Second opcode 4 selects first model word
// - Second opcode 5 selects second model word
// - First word: top zero, context remap one
// - First word: auxiliary control field one
// - First word: no tightly coupled memory
// - First word: no outer shareable attribute
// - First word: no hardware cache coherency
// - First word: physical memory arch absent
// - First word: virtual memory arch three
// - Second word: branch buffer field two
// - Second word: no test and clean
// - Second word: no unified whole-cache ops
// - Second word: split whole-cache field zero
// - Second word: no unified set/way ops
// - Second word: split set/way field zero
// - Second word: no unified address ops
// - Second word: split address field zero
module mmf_feature_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cpReq,
  input  wire logic        cpWrite,
  input  wire logic        cpPriv,
  input  wire logic        cpSecure,
  input  wire logic [2:0]  cpOpc1,
  input  wire logic [3:0]  cpCrn,
  input  wire logic [3:0]  cpCrm,
  input  wire logic [2:0]  cpOpc2,
  input  wire logic [3:0]  cpRd,
  output logic             respValid_ff,
  output logic             respUndef_ff,
  output logic [31:0]      respData_ff,
  output logic [3:0]       respRd_ff
);

  logic        rstSync1_ff;
  logic        rstSync2_ff;
  logic        rstnSync;
  logic        selAux;
  logic        selMm0;
  logic        selMm1;
  logic        bankHit;
  logic        reqHit;
  logic        readOk;
  logic        trapReq;
  logic        permAux;
  logic        permMm0;
  logic        permMm1;
  logic [31:0] nxt_respData;
  logic [3:0]  nxt_respRd;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  assign rstnSync = rstSync2_ff;

  // Register field decode
  mmf_cp_decode uDecode (
    .opc1    (cpOpc1),
    .crn     (cpCrn),
    .crm     (cpCrm),
    .opc2    (cpOpc2),
    .selAux  (selAux),
    .selMm0  (selMm0),
    .selMm1  (selMm1),
    .bankHit (bankHit)
  );

  // Access check; security state plays no part
  assign reqHit  = cpReq & bankHit;
  assign readOk  = reqHit & ~cpWrite & cpPriv;
  assign trapReq = reqHit & (cpWrite | ~cpPriv);

  // Per-word permitted reads
  assign permAux = readOk & selAux;
  assign permMm0 = readOk & selMm0;
  assign permMm1 = readOk & selMm1;

  // Word select; a refused access returns zero
  always_comb begin
    nxt_respData = mmf_pkg::RESP_DATA_RST;
    if (!readOk) begin
      nxt_respData = mmf_pkg::RESP_DATA_RST;
    end else if (selAux) begin
      nxt_respData = mmf_pkg::AUX_WORD;
    end else if (selMm0) begin
      nxt_respData = mmf_pkg::MM0_WORD;
    end else if (selMm1) begin
      nxt_respData = mmf_pkg::MM1_WORD;
    end
  end

  // Destination register travels with the answer
  assign nxt_respRd = reqHit ? cpRd : mmf_pkg::RESP_RD_RST;

  // Answer strobe, one cycle per claimed request
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      respValid_ff <= 1'b0;
    end else begin
      respValid_ff <= reqHit;
    end
  end

  // Undefined instruction strobe
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      respUndef_ff <= 1'b0;
    end else begin
      respUndef_ff <= trapReq;
    end
  end

  // Read data, shared by both security states
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      respData_ff <= mmf_pkg::RESP_DATA_RST;
    end else begin
      respData_ff <= nxt_respData;
    end
  end

  // Destination register index
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      respRd_ff <= mmf_pkg::RESP_RD_RST;
    end else begin
      respRd_ff <= nxt_respRd;
    end
  end

  // Checks on the answer, one cycle after each request
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstnSync);

  AST_AUX_ZERO:
    assert property (
      $past(permAux) |->
        respValid_ff && !respUndef_ff &&
        respData_ff == 32'h0000_0000
    ) else $error("auxiliary word not zero");

  AST_SHARED_NS:
    assert property (
      $past(permMm1 && !cpSecure) |->
        respData_ff == mmf_pkg::MM1_WORD
    ) else $error("nonsecure read differs");

  AST_SHARED_S:
    assert property (
      $past(permMm1 && cpSecure) |->
        respData_ff == mmf_pkg::MM1_WORD
    ) else $error("secure read differs");

  AST_SHARED_MM0:
    assert property (
      $past(permMm0) |->
        respData_ff == mmf_pkg::MM0_WORD
    ) else $error("first word read differs");

  AST_USER_READ:
    assert property (
      $past(reqHit && !cpWrite && !cpPriv) |->
        respValid_ff && respUndef_ff &&
        respData_ff == mmf_pkg::RESP_DATA_RST
    ) else $error("user read not refused");

  AST_PRIV_READ:
    assert property (
      $past(readOk) |-> respValid_ff && !respUndef_ff
    ) else $error("privileged read refused");

  AST_WRITE_TRAP:
    assert property (
      $past(reqHit && cpWrite) |->
        respUndef_ff && respValid_ff &&
        respData_ff == mmf_pkg::RESP_DATA_RST
    ) else $error("write not trapped");

  AST_NO_SPURIOUS:
    assert property (
      !$past(reqHit) |-> !respValid_ff && !respUndef_ff
    ) else $error("answer without request");

  AST_IDLE_ZERO:
    assert property (
      !$past(reqHit) |->
        respData_ff == 32'h0000_0000 && respRd_ff == 4'h0
    ) else $error("idle answer not zero");

  AST_SEL_AUX:
    assert property (
      cpReq && !cpWrite && cpPriv &&
      cpOpc1 == 3'h0 && cpCrn == 4'h0 &&
      cpCrm == 4'h1 && cpOpc2 == 3'h3 |=>
        respValid_ff && respData_ff == 32'h0000_0000
    ) else $error("opcode 3 not auxiliary");

  AST_SEL_MM0:
    assert property (
      cpReq && !cpWrite && cpPriv &&
      cpOpc1 == 3'h0 && cpCrn == 4'h0 &&
      cpCrm == 4'h1 && cpOpc2 == 3'h4 |=>
        respValid_ff && respData_ff == 32'h0110_0003
    ) else $error("opcode 4 not first word");

  AST_SEL_MM1:
    assert property (
      cpReq && !cpWrite && cpPriv &&
      cpOpc1 == 3'h0 && cpCrn == 4'h0 &&
      cpCrm == 4'h1 && cpOpc2 == 3'h5 |=>
        respValid_ff && respData_ff == 32'h2000_0000
    ) else $error("opcode 5 not second word");

  AST_MM0_TOP:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB7_LSB +: 4] == 4'h0
    ) else $error("first word top field set");

  AST_MM0_CTX:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB6_LSB +: 4] == 4'h1
    ) else $error("context remap field wrong");

  AST_MM0_AUXCTL:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB5_LSB +: 4] == 4'h1
    ) else $error("auxiliary control field wrong");

  AST_MM0_COUPLED:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB4_LSB +: 4] == 4'h0
    ) else $error("coupled memory field wrong");

  AST_MM0_OSH:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB3_LSB +: 4] == 4'h0
    ) else $error("outer shareable field wrong");

  AST_MM0_COH:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB2_LSB +: 4] == 4'h0
    ) else $error("coherency field wrong");

  AST_MM0_PHYS:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB1_LSB +: 4] == 4'h0
    ) else $error("physical arch field wrong");

  AST_MM0_VIRT:
    assert property (
      $past(permMm0) |->
        respData_ff[mmf_pkg::NIB0_LSB +: 4] == 4'h3
    ) else $error("virtual arch field wrong");

  AST_MM1_BRANCH:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB7_LSB +: 4] == 4'h2
    ) else $error("branch buffer field wrong");

  AST_MM1_TSTCLN:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB6_LSB +: 4] == 4'h0
    ) else $error("test and clean field wrong");

  AST_MM1_UNIALL:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB5_LSB +: 4] == 4'h0
    ) else $error("unified whole-cache field wrong");

  AST_MM1_SPLALL:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB4_LSB +: 4] == 4'h0
    ) else $error("split whole-cache field wrong");

  AST_MM1_UNISW:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB3_LSB +: 4] == 4'h0
    ) else $error("unified set/way field wrong");

  AST_MM1_SPLSW:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB2_LSB +: 4] == 4'h0
    ) else $error("split set/way field wrong");

  AST_MM1_UNIVA:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB1_LSB +: 4] == 4'h0
    ) else $error("unified address field wrong");

  AST_MM1_SPLVA:
    assert property (
      $past(permMm1) |->
        respData_ff[mmf_pkg::NIB0_LSB +: 4] == 4'h0
    ) else $error("split address field wrong");

  AST_DEST_REG:
    assert property (
      $past(readOk) |-> respRd_ff == $past(cpRd)
    ) else $error("destination register lost");

  AST_BACK_TO_BACK:
    assert property (
      permMm0 ##1 permAux |->
        ##1 respData_ff == mmf_pkg::AUX_WORD &&
        $past(respData_ff) == mmf_pkg::MM0_WORD
    ) else $error("back to back reads mixed");

endmodule

`default_nettype wire

/* mmf_feature_regs_tb_top.sv */
// Self-checking bench for the feature identification bank.
// Assumes the bank answers one cycle after a claimed request.
`timescale 1ns/1ps
`default_nettype none

// Compares a design value with its expected value and counts it
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    $display("mismatch at %0t: output differs from expected", $time); \
    err_count++; \
  end \
end

module mmf_feature_regs_tb_top;
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        cpReq    = 1'b0;
  logic        cpWrite  = 1'b0;
  logic        cpPriv   = 1'b0;
  logic        cpSecure = 1'b0;
  logic [2:0]  cpOpc1   = 3'h0;
  logic [3:0]  cpCrn    = 4'h0;
  logic [3:0]  cpCrm    = 4'h0;
  logic [2:0]  cpOpc2   = 3'h0;
  logic [3:0]  cpRd     = 4'h0;
  logic        respValid_ff;
  logic        respUndef_ff;
  logic [31:0] respData_ff;
  logic [3:0]  respRd_ff;
  int          err_count = 0;
  int          tests_run = 0;

  // Device under test
  mmf_feature_regs uut (
    .clk          (clk),
    .rstn         (rstn),
    .cpReq        (cpReq),
    .cpWrite      (cpWrite),
    .cpPriv       (cpPriv),
    .cpSecure     (cpSecure),
    .cpOpc1       (cpOpc1),
    .cpCrn        (cpCrn),
    .cpCrm        (cpCrm),
    .cpOpc2       (cpOpc2),
    .cpRd         (cpRd),
    .respValid_ff (respValid_ff),
    .respUndef_ff (respUndef_ff),
    .respData_ff  (respData_ff),
    .respRd_ff    (respRd_ff)
  );

  // Core clock, 100 ns period
  always #50 clk = ~clk;

  // Word each second opcode should read back
  function automatic logic [31:0] expWord(input logic [2:0] o2);
    case (o2)
      3'h4:    expWord = 32'h0110_0003;
      3'h5:    expWord = 32'h2000_0000;
      default: expWord = 32'h0000_0000;
    endcase
  endfunction

  // Presents one request; called at a falling edge
  task automatic go(input logic wr, input logic pv, input logic sc,
                    input logic [2:0] o1, input logic [3:0] n,
                    input logic [3:0] m, input logic [2:0] o2,
                    input logic [3:0] rd);
    cpReq    = 1'b1;
    cpWrite  = wr;
    cpPriv   = pv;
    cpSecure = sc;
    cpOpc1   = o1;
    cpCrn    = n;
    cpCrm    = m;
    cpOpc2   = o2;
    cpRd     = rd;
  endtask

  // Checks all four outputs at once
  task automatic chk(input logic v, input logic u, input logic [31:0] d,
                     input logic [3:0] r);
    `CHK(respValid_ff, v)
    `CHK(respUndef_ff, u)
    `CHK(respData_ff, d)
    `CHK(respRd_ff, r)
  endtask

  // One whole access: request, answer next cycle, then idle
  task automatic one(input logic wr, input logic pv, input logic sc,
                     input logic [2:0] o1, input logic [3:0] n,
                     input logic [3:0] m, input logic [2:0] o2,
                     input logic [3:0] rd, input logic v, input logic u,
                     input logic [31:0] d, input logic [3:0] r);
    go(wr, pv, sc, o1, n, m, o2, rd);
    @(negedge clk);
    cpReq = 1'b0;
    chk(v, u, d, r);
    @(negedge clk);
    chk(1'b0, 1'b0, 32'h0, 4'h0);
  endtask

  // Prints the counts and the verdict, then stops
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    // Privileged reads in both security states
    for (int s = 0; s < 2; s++) begin
      for (int k = 3; k < 6; k++) begin
        one(1'b0, 1'b1, s[0], 3'h0, 4'h0, 4'h1, k[2:0], 4'(k + 4 * s),
            1'b1, 1'b0, expWord(k[2:0]), 4'(k + 4 * s));
      end
    end
    $display("test done: privileged reads");
    // Field by field view of both model words
    one(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h4, 4'hf,
        1'b1, 1'b0, 32'h0110_0003, 4'hf);
    one(1'b0, 1'b1, 1'b1, 3'h0, 4'h0, 4'h1, 3'h5, 4'h0,
        1'b1, 1'b0, 32'h2000_0000, 4'h0);
    $display("test done: field values");
    // Writes in every mode and user reads give undefined
    for (int c = 0; c < 12; c++) begin
      if (c[1:0] != 2'h2)
        one(c[0], c[1], c[2], 3'h0, 4'h0, 4'h1, 3'(3 + c / 4), 4'h9,
            1'b1, 1'b1, 32'h0, 4'h9);
    end
    $display("test done: refused accesses");
    // Neighbouring selectors get no answer at all
    for (int k = 0; k < 8; k++) begin
      if (k < 3 || k > 5)
        one(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, k[2:0], 4'h2,
            1'b0, 1'b0, 32'h0, 4'h0);
    end
    one(1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h1, 3'h4, 4'h2,
        1'b0, 1'b0, 32'h0, 4'h0);
    one(1'b0, 1'b1, 1'b0, 3'h0, 4'h1, 4'h1, 3'h4, 4'h2,
        1'b0, 1'b0, 32'h0, 4'h0);
    one(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h0, 3'h4, 4'h2,
        1'b0, 1'b0, 32'h0, 4'h0);
    $display("test done: unclaimed selectors");
    // Back-to-back requests, a write in the middle
    go(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h5, 4'h1);
    @(negedge clk);
    go(1'b1, 1'b1, 1'b1, 3'h0, 4'h0, 4'h1, 3'h4, 4'h2);
    chk(1'b1, 1'b0, 32'h2000_0000, 4'h1);
    @(negedge clk);
    go(1'b0, 1'b1, 1'b1, 3'h0, 4'h0, 4'h1, 3'h4, 4'h3);
    chk(1'b1, 1'b1, 32'h0, 4'h2);
    @(negedge clk);
    go(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h3, 4'h4);
    chk(1'b1, 1'b0, 32'h0110_0003, 4'h3);
    @(negedge clk);
    go(1'b0, 1'b0, 1'b0, 3'h0, 4'h0, 4'h1, 3'h3, 4'h5);
    chk(1'b1, 1'b0, 32'h0, 4'h4);
    @(negedge clk);
    cpReq = 1'b0;
    chk(1'b1, 1'b1, 32'h0, 4'h5);
    @(negedge clk);
    chk(1'b0, 1'b0, 32'h0, 4'h0);
    $display("test done: back to back");
    // Reset during an answer clears it while a request stands
    go(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h4, 4'h6);
    @(negedge clk);
    chk(1'b1, 1'b0, 32'h0110_0003, 4'h6);
    rstn = 1'b0;
    @(negedge clk);
    chk(1'b0, 1'b0, 32'h0, 4'h0);
    cpReq = 1'b0;
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    one(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h4, 4'h6,
        1'b1, 1'b0, 32'h0110_0003, 4'h6);
    $display("test done: mid-run reset");
    wrap_up();
  end
endmodule

`undef CHK
`default_nettype wire
